/* acc_defines.svh */
// Offsets, field positions, reset values and timing counts of the comparator control block.
// Included by the package and by the design; holds definitions only.
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
// Register indices; the byte address on the bus is four times the index.
`define ACC_IDX_CTRL0       14'h108c
`define ACC_IDX_CTRL1       14'h108d
`define ACC_IDX_INV_SEL     14'h108e
`define ACC_IDX_NONINV_SEL  14'h108f
`define ACC_IDX_MIRROR      14'h109f
`define ACC_IDX_IRQ_STATUS  14'h10a0
`define ACC_IDX_IRQ_MASK    14'h10a1
`define ACC_IDX_ADC_TRIG    14'h10a2
// Control register zero fields.
`define ACC_C0_ENABLE       7
`define ACC_C0_OUTPUT       6
`define ACC_C0_INVERT       4
`define ACC_C0_HYST         1
`define ACC_C0_SYNC         0
// Control register one fields.
`define ACC_C1_RISE_IE      1
`define ACC_C1_FALL_IE      0
// Interrupt status and mask fields.
`define ACC_IRQ_EDGE        0
`define ACC_IRQ_ADC         1
// Input select codes.
`define ACC_SEL_GROUND      3'h7
`define ACC_SEL_REF2        3'h6
`define ACC_SEL_NC5         3'h5
`define ACC_SEL_NC4         3'h4
`define ACC_SEL_CONV        3'h4
`define ACC_SEL_EXT0        3'h0
// Reset values.
`define ACC_RST_BYTE        8'h00
`define ACC_RST_SEL         3'h0
// Instruction cycle is four system clocks.
`define ACC_INSTR_DIV       4
`endif

/* acc_pkg.sv */
// Types shared by the comparator control block.
// Assumes acc_defines.svh is on the include path.
`include "acc_defines.svh"
package acc_pkg;
  typedef logic [2:0] acc_sel_t;
  typedef logic [7:0] acc_byte_t;
endpackage

/* acc_top.sv */
// Digital control and status logic of one analog comparator, with a Wishbone register slave.
// Assumes the analog core result, the companion timer clock and sleep arrive as inputs;
// the raw result and timer clock are asynchronous, sleep and trigger select users are synchronous.
// Operation
// - Inverting select routes ground, reference, external inputs.
// - Noninverting select routes ground, reference, converter, input.
// - Pending enabled comparator interrupt wakes the device.
// - Sync output frozen in sleep on system-clocked timer.
// - ADC trigger on rising output when selected.
// - Control zero bit 7 enables comparator.
// - Control zero bit 6 reads polarity-adjusted result.
// - Control zero bit 4 inverts output everywhere.
// - Control zero bit 1 drives hysteresis enable.
// - Control zero bit 0 syncs output to timer.
// - Control one bit 1 flags rising edges.
// - Control one bit 0 flags falling edges.
// - Mirror register bit 0 copies output bit.
// - Disabled comparator disconnects inputs, forces result to zero before polarity.
// - Flag stays set until software clears it.
// - Internal output latched once per instruction cycle.
// - Polarity toggle while disabled still changes output.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
`include "acc_defines.svh"
module acc_top
  import acc_pkg::*;
#(
  parameter acc_byte_t ADC_TRIG_CODE = 8'h01
)
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [15:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        cmp_raw_in,
  input  wire logic        tmr_clk_in,
  input  wire logic        tmr_sysclk_src_in,
  input  wire logic        sleep_in,
  output logic             cmp_enable_out,
  output logic             hysteresis_enable_out,
  output acc_sel_t         inverting_input_select_out,
  output logic             inverting_connect_out,
  output acc_sel_t         noninverting_input_select_out,
  output logic             noninverting_connect_out,
  output logic             cmp_ext_out,
  output logic             adc_trig_out,
  output logic             irq_out,
  output logic             wake_out
);

  logic       enable_q;
  logic       output_invert_q;
  logic       hysteresis_enable_q;
  logic       sync_mode_q;
  logic       rising_edge_irq_enable_q;
  logic       falling_edge_irq_enable_q;
  acc_sel_t   inverting_input_select_q;
  acc_sel_t   noninverting_input_select_q;
  acc_byte_t  adc_trigger_select_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic       output_mirror_bit_q;
  logic       output_mirror_d;
  logic       raw_s1_q;
  logic       raw_s2_q;
  logic       raw_s3_q;
  logic       raw_level_q;
  logic       tmr_s1_q;
  logic       tmr_s2_q;
  logic       tmr_s3_q;
  logic       tmr_level_q;
  logic       tmr_fall;
  logic [1:0] instr_cnt_q;
  logic       instr_tick;
  logic       out_prev_q;
  logic       rise_evt;
  logic       fall_evt;
  logic       edge_set;
  logic       adc_set;
  logic       bus_req;
  logic       wr_lo;
  logic [13:0] idx;
  logic [1:0] status_clr;
  acc_byte_t  rd_byte;

  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign idx     = wb_adr_in[15:2];
  assign wr_lo   = bus_req & wb_we_in & wb_sel_in[0];

  // Three flops on the raw result; a level change is taken only when the last two agree.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      raw_s1_q    <= 1'b0;
      raw_s2_q    <= 1'b0;
      raw_s3_q    <= 1'b0;
      raw_level_q <= 1'b0;
    end
    else
    begin
      raw_s1_q <= cmp_raw_in;
      raw_s2_q <= raw_s1_q;
      raw_s3_q <= raw_s2_q;
      if (raw_s2_q == raw_s3_q)
      begin
        raw_level_q <= raw_s3_q;
      end
    end
  end

  // The timer clock is sampled the same way; its falling edge becomes a one-cycle enable.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tmr_s1_q    <= 1'b0;
      tmr_s2_q    <= 1'b0;
      tmr_s3_q    <= 1'b0;
      tmr_level_q <= 1'b0;
    end
    else
    begin
      tmr_s1_q <= tmr_clk_in;
      tmr_s2_q <= tmr_s1_q;
      tmr_s3_q <= tmr_s2_q;
      if (tmr_s2_q == tmr_s3_q)
      begin
        tmr_level_q <= tmr_s3_q;
      end
    end
  end

  assign tmr_fall = tmr_level_q & (tmr_s2_q == tmr_s3_q) & ~tmr_s3_q;

  // Instruction cycle divider.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      instr_cnt_q <= 2'h0;
    end
    else
    begin
      instr_cnt_q <= instr_cnt_q + 2'h1;
    end
  end

  assign instr_tick = (instr_cnt_q == 2'(`ACC_INSTR_DIV - 1));

  // Polarity is applied after the enable gate, so toggling it while disabled still moves the output.
  assign output_mirror_d = (enable_q & raw_level_q) ^ output_invert_q;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      output_mirror_bit_q <= 1'b0;
    end
    else if (instr_tick)
    begin
      output_mirror_bit_q <= output_mirror_d;
    end
  end

  // The external copy is unlatched unless sync mode holds it to the timer's falling edge.
  // A timer run from the system clock stops in sleep, so the synced copy then stays put.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cmp_ext_out <= 1'b0;
    end
    else if (!sync_mode_q)
    begin
      cmp_ext_out <= output_mirror_d;
    end
    else if (tmr_fall && !(sleep_in && tmr_sysclk_src_in))
    begin
      cmp_ext_out <= output_mirror_d;
    end
  end

  // Edge detection on the latched output bit.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      out_prev_q <= 1'b0;
    end
    else
    begin
      out_prev_q <= output_mirror_bit_q;
    end
  end

  assign rise_evt = output_mirror_bit_q & ~out_prev_q;
  assign fall_evt = ~output_mirror_bit_q & out_prev_q;
  assign edge_set = (rise_evt & rising_edge_irq_enable_q) | (fall_evt & falling_edge_irq_enable_q);
  assign adc_set  = rise_evt & (adc_trigger_select_q == ADC_TRIG_CODE);

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      adc_trig_out <= 1'b0;
    end
    else
    begin
      adc_trig_out <= adc_set;
    end
  end

  // Sticky status, cleared by writing one; a set in the same cycle as the clear wins.
  assign status_clr = (wr_lo && idx == `ACC_IDX_IRQ_STATUS) ? wb_dat_in[1:0] : 2'h0;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      irq_status_q <= 2'h0;
    end
    else
    begin
      irq_status_q[`ACC_IRQ_EDGE] <= edge_set | (irq_status_q[`ACC_IRQ_EDGE] & ~status_clr[`ACC_IRQ_EDGE]);
      irq_status_q[`ACC_IRQ_ADC]  <= adc_set | (irq_status_q[`ACC_IRQ_ADC] & ~status_clr[`ACC_IRQ_ADC]);
    end
  end

  // The mask's edge bit doubles as the peripheral enable that gates wake-up.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      irq_out  <= 1'b0;
      wake_out <= 1'b0;
    end
    else
    begin
      irq_out  <= |(irq_status_q & irq_mask_q);
      wake_out <= sleep_in & irq_status_q[`ACC_IRQ_EDGE] & irq_mask_q[`ACC_IRQ_EDGE];
    end
  end

  // Control register writes; only the low byte lane carries register data.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      enable_q                  <= 1'b0;
      output_invert_q           <= 1'b0;
      hysteresis_enable_q       <= 1'b0;
      sync_mode_q               <= 1'b0;
      rising_edge_irq_enable_q  <= 1'b0;
      falling_edge_irq_enable_q <= 1'b0;
      inverting_input_select_q    <= `ACC_RST_SEL;
      noninverting_input_select_q <= `ACC_RST_SEL;
      adc_trigger_select_q      <= `ACC_RST_BYTE;
      irq_mask_q                <= 2'h0;
    end
    else if (wr_lo)
    begin
      unique case (idx)
        `ACC_IDX_CTRL0:
        begin
          enable_q            <= wb_dat_in[`ACC_C0_ENABLE];
          output_invert_q     <= wb_dat_in[`ACC_C0_INVERT];
          hysteresis_enable_q <= wb_dat_in[`ACC_C0_HYST];
          sync_mode_q         <= wb_dat_in[`ACC_C0_SYNC];
        end
        `ACC_IDX_CTRL1:
        begin
          rising_edge_irq_enable_q  <= wb_dat_in[`ACC_C1_RISE_IE];
          falling_edge_irq_enable_q <= wb_dat_in[`ACC_C1_FALL_IE];
        end
        `ACC_IDX_INV_SEL:
        begin
          inverting_input_select_q <= wb_dat_in[2:0];
        end
        `ACC_IDX_NONINV_SEL:
        begin
          noninverting_input_select_q <= wb_dat_in[2:0];
        end
        `ACC_IDX_ADC_TRIG:
        begin
          adc_trigger_select_q <= wb_dat_in[7:0];
        end
        `ACC_IDX_IRQ_MASK:
        begin
          irq_mask_q <= wb_dat_in[1:0];
        end
        default:
        begin
          irq_mask_q <= irq_mask_q;
        end
      endcase
    end
  end

  // Analog-facing controls; a disabled comparator has every input path open.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cmp_enable_out                <= 1'b0;
      hysteresis_enable_out         <= 1'b0;
      inverting_input_select_out    <= `ACC_RST_SEL;
      inverting_connect_out         <= 1'b0;
      noninverting_input_select_out <= `ACC_RST_SEL;
      noninverting_connect_out      <= 1'b0;
    end
    else
    begin
      cmp_enable_out                <= enable_q;
      hysteresis_enable_out         <= hysteresis_enable_q;
      inverting_input_select_out    <= inverting_input_select_q;
      noninverting_input_select_out <= noninverting_input_select_q;
      inverting_connect_out         <= enable_q & (inverting_input_select_q != `ACC_SEL_NC5) &
                                       (inverting_input_select_q != `ACC_SEL_NC4);
      noninverting_connect_out      <= enable_q & ((noninverting_input_select_q == `ACC_SEL_GROUND) |
                                       (noninverting_input_select_q == `ACC_SEL_REF2) |
                                       (noninverting_input_select_q == `ACC_SEL_CONV) |
                                       (noninverting_input_select_q == `ACC_SEL_EXT0));
    end
  end

  // Read multiplexer; unmapped addresses and unimplemented bits read zero.
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (idx)
      `ACC_IDX_CTRL0:
      begin
        rd_byte[`ACC_C0_ENABLE] = enable_q;
        rd_byte[`ACC_C0_OUTPUT] = output_mirror_bit_q;
        rd_byte[`ACC_C0_INVERT] = output_invert_q;
        rd_byte[`ACC_C0_HYST]   = hysteresis_enable_q;
        rd_byte[`ACC_C0_SYNC]   = sync_mode_q;
      end
      `ACC_IDX_CTRL1:
      begin
        rd_byte[`ACC_C1_RISE_IE] = rising_edge_irq_enable_q;
        rd_byte[`ACC_C1_FALL_IE] = falling_edge_irq_enable_q;
      end
      `ACC_IDX_INV_SEL:
      begin
        rd_byte[2:0] = inverting_input_select_q;
      end
      `ACC_IDX_NONINV_SEL:
      begin
        rd_byte[2:0] = noninverting_input_select_q;
      end
      `ACC_IDX_MIRROR:
      begin
        rd_byte[0] = output_mirror_bit_q;
      end
      `ACC_IDX_IRQ_STATUS:
      begin
        rd_byte[1:0] = irq_status_q;
      end
      `ACC_IDX_IRQ_MASK:
      begin
        rd_byte[1:0] = irq_mask_q;
      end
      `ACC_IDX_ADC_TRIG:
      begin
        rd_byte = adc_trigger_select_q;
      end
      default:
      begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Every request is answered one cycle after it is seen, mapped or not.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_out <= bus_req;
      if (bus_req && !wb_we_in)
      begin
        wb_dat_out <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule

/* acc_core_model.sv */
// Model of the analog comparator core and of the companion timer clock.
// The bench drives the analog condition and timer run; one system clock.
`timescale 1ns/100ps
module acc_core_model (
  input  wire logic clk_in,
  input  wire logic en_in,
  input  wire logic pc_in,
  input  wire logic nc_in,
  input  wire logic diff_in,
  input  wire logic run_in,
  output logic      raw_out,
  output logic      tclk_out
);
  logic [1:0] div_q = 2'h0;
  // A disabled or unconnected core gives no result, so its output rests low.
  assign raw_out = en_in & pc_in & nc_in & diff_in;
  // The timer ends its high phase before it stops, so it rests low.
  always_ff @(posedge clk_in)
  begin
    if (run_in || div_q[1])
      div_q <= div_q + 2'h1;
  end
  assign tclk_out = div_q[1];
endmodule

/* acc_checker_asserts.sv */
// Port assertions of the comparator control block.
// Bound to acc_top; sees only its ports.
`timescale 1ns/100ps
module acc_checker
  import acc_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        sleep_in,
  input wire logic        cmp_enable_out,
  input wire acc_sel_t    inverting_input_select_out,
  input wire logic        inverting_connect_out,
  input wire acc_sel_t    noninverting_input_select_out,
  input wire logic        noninverting_connect_out,
  input wire logic        adc_trig_out,
  input wire logic        irq_out,
  input wire logic        wake_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus request not answered next cycle");
  a_read_high_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("read data above the low byte not zero");
  a_off_disconnect: assert property (!cmp_enable_out && !$past(cmp_enable_out) |->
    !inverting_connect_out && !noninverting_connect_out) else $error("inputs connected while disabled");
  a_inv_route: assert property (cmp_enable_out && $stable(cmp_enable_out) && $stable(inverting_input_select_out)
    |-> inverting_connect_out == !(inverting_input_select_out inside {3'h4, 3'h5})) else $error("inverting route");
  a_noninv_route: assert property (cmp_enable_out && $stable(cmp_enable_out)
    && $stable(noninverting_input_select_out) |-> noninverting_connect_out
    == (noninverting_input_select_out inside {3'h0, 3'h4, 3'h6, 3'h7})) else $error("noninverting route");
  a_trig_single: assert property (adc_trig_out |=> !adc_trig_out [*7])
    else $error("trigger pulse repeated too soon");
  a_wake_cause: assert property (wake_out |-> irq_out && $past(sleep_in))
    else $error("wake without pending interrupt in sleep");
  a_irq_sticky: assert property ($rose(irq_out) && !(wb_cyc_in && wb_stb_in && wb_we_in) |=> irq_out)
    else $error("interrupt dropped without a write");
  c_irq: cover property ($rose(irq_out));
  c_trig: cover property (adc_trig_out);
  c_wake: cover property (wake_out);
endmodule
bind acc_top acc_checker u_acc_checker (.*);

/* tb_top.sv */
// Self-checking bench of the comparator control block.
// Drives the register bus, sleep and timer source; a core model gives the result and timer clock.
`timescale 1ns/100ps
module tb_top
  import acc_pkg::*;
;
  localparam logic [15:0] A0 = 16'h4230, A1 = 16'h4234, AN = 16'h4238, AP = 16'h423c;
  localparam logic [15:0] AM = 16'h427c, AS = 16'h4280, AK = 16'h4284, AT = 16'h4288;
  logic        clk = 1'b0, rstn = 1'b0, req = 1'b0, we = 1'b0;
  logic        dif = 1'b0, run = 1'b0, slp = 1'b0, src = 1'b0;
  logic [15:0] adr = 16'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic        ack, en, hy, pc, nc, ext, trg, irq, wk, raw, tck;
  acc_sel_t    iso, nso;
  logic [7:0]  q;
  int          fail_count = 0, n_checks = 0, cyc_cnt = 0;

  acc_top #(.ADC_TRIG_CODE(8'h01)) DUT (.clk_in(clk), .resetn_in(rstn), .wb_cyc_in(req), .wb_stb_in(req),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wd), .wb_dat_out(rdat), .wb_ack_out(ack),
    .cmp_raw_in(raw), .tmr_clk_in(tck), .tmr_sysclk_src_in(src), .sleep_in(slp), .cmp_enable_out(en),
    .hysteresis_enable_out(hy), .inverting_input_select_out(iso), .inverting_connect_out(nc),
    .noninverting_input_select_out(nso), .noninverting_connect_out(pc), .cmp_ext_out(ext),
    .adc_trig_out(trg), .irq_out(irq), .wake_out(wk));
  acc_core_model u_core (.clk_in(clk), .en_in(en), .pc_in(pc), .nc_in(nc), .diff_in(dif), .run_in(run),
    .raw_out(raw), .tclk_out(tck));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      fail_count++;
      final_report;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // Entered just after a rising edge; holds the request until ack is sampled high.
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = rdat[7:0];
    req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic watch(input logic v, input logic e);
    logic s;
    s = 1'b0;
    dif <= v;
    repeat (16)
    begin
      @(posedge clk);
      s |= (trg === 1'b1);
    end
    chk(s, e);
  endtask

  task automatic t_regs;
    logic [15:0] al [6];
    al = '{A0, A1, AN, AP, AM, 16'h4300};
    foreach (al[i])
      rc(al[i], 8'h00);
    wr(A1, 8'hff);
    rc(A1, 8'h03);
    wr(AN, 8'hff);
    rc(AN, 8'h07);
    wr(AM, 8'hff);
    rc(AM, 8'h00);
    wr(A0, 8'h42);
    tick(12);
    rc(A0, 8'h02);
    chk(hy, 1'b1);
    wr(A0, 8'h00);
    chk(hy, 1'b0);
    $display("registers finished");
  endtask

  task automatic t_sel;
    wr(A0, 8'h80);
    chk(en, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      wr(AN, 8'(i));
      wr(AP, 8'(i));
      chk({iso, nso}, {2{3'(i)}});
      chk(nc, 1'(i != 4 && i != 5));
      chk(pc, 1'(i inside {0, 4, 6, 7}));
    end
    wr(A0, 8'h00);
    chk(pc | nc, 1'b0);
    $display("select finished");
  endtask

  task automatic t_out;
    wr(AN, 8'h00);
    wr(AP, 8'h00);
    dif <= 1'b1;
    wr(A0, 8'h80);
    tick(12);
    rc(A0, 8'hc0);
    rc(AM, 8'h01);
    chk(ext, 1'b1);
    wr(A0, 8'h90);
    tick(12);
    rc(A0, 8'h90);
    chk(ext, 1'b0);
    wr(A0, 8'h00);
    tick(12);
    rc(AM, 8'h00);
    $display("output finished");
  endtask

  task automatic t_irq;
    wr(A1, 8'h02);
    wr(AK, 8'h03);
    wr(AS, 8'h03);
    wr(A0, 8'h10);
    tick(12);
    chk(irq, 1'b1);
    rc(AS, 8'h01);
    wr(AS, 8'h01);
    tick(2);
    chk(irq, 1'b0);
    wr(A0, 8'h00);
    tick(12);
    rc(AS, 8'h00);
    wr(A1, 8'h01);
    wr(A0, 8'h10);
    tick(12);
    rc(AS, 8'h00);
    wr(A0, 8'h00);
    tick(12);
    rc(AS, 8'h01);
    wr(AK, 8'h00);
    slp <= 1'b1;
    tick(2);
    chk({irq, wk}, 2'b00);
    wr(AK, 8'h01);
    chk({irq, wk}, 2'b11);
    slp <= 1'b0;
    wr(AS, 8'h03);
    $display("interrupt finished");
  endtask

  task automatic t_adc;
    dif <= 1'b0;
    wr(AT, 8'h01);
    wr(A1, 8'h00);
    wr(A0, 8'h80);
    tick(12);
    wr(AS, 8'h03);
    watch(1'b1, 1'b1);
    rc(AS, 8'h02);
    watch(1'b0, 1'b0);
    $display("trigger finished");
  endtask

  task automatic t_sync;
    dif <= 1'b1;
    wr(A0, 8'h81);
    run <= 1'b1;
    tick(40);
    chk(ext, 1'b1);
    run <= 1'b0;
    tick(8);
    dif <= 1'b0;
    tick(40);
    chk(ext, 1'b1);
    run <= 1'b1;
    tick(40);
    chk(ext, 1'b0);
    slp <= 1'b1;
    src <= 1'b1;
    dif <= 1'b1;
    tick(40);
    chk(ext, 1'b0);
    slp <= 1'b0;
    tick(40);
    chk(ext, 1'b1);
    src <= 1'b0;
    $display("sync finished");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_sel;
    t_out;
    t_irq;
    t_adc;
    t_sync;
    final_report;
  end
endmodule
